// File: htc_pkg.sv
package htc_pkg;
    // ****************************************************
    // register map (byte addresses on the bus)
    // ****************************************************
    localparam logic [15:0] ADDR_TFR = 16'hffac;
    localparam logic [15:0] ADDR_STS = 16'hffb0;
    localparam logic [15:0] ADDR_MSK = 16'hffb4;
    localparam logic [15:0] ADDR_OVL = 16'hffb8;
    localparam logic [15:0] ADDR_UNL = 16'hffbc;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] RST_OVL = 16'h0000;
    localparam logic [15:0] RST_UNL = 16'hffff;
    // ****************************************************
    // flag positions
    // ****************************************************
    localparam int B_NMI = 15;
    localparam int B_OVF = 14;
    localparam int B_UNF = 13;
    localparam int B_UND = 7;
    localparam int B_MAC = 6;
    localparam int B_PRT = 3;
    localparam int B_ODW = 2;
    localparam int B_ODB = 1;
    localparam int B_BUS = 0;
    localparam logic [15:0] CLS_A = 16'he000;
    localparam logic [15:0] CLS_B = 16'h00cf;
    // ****************************************************
    // vectors and trap numbers
    // ****************************************************
    localparam logic [23:0] VEC_RST = 24'h00_0000;
    localparam logic [23:0] VEC_NMI = 24'h00_0008;
    localparam logic [23:0] VEC_OVF = 24'h00_0010;
    localparam logic [23:0] VEC_UNF = 24'h00_0018;
    localparam logic [23:0] VEC_B = 24'h00_0028;
    localparam logic [7:0] NUM_RST = 8'h00;
    localparam logic [7:0] NUM_NMI = 8'h02;
    localparam logic [7:0] NUM_OVF = 8'h04;
    localparam logic [7:0] NUM_UNF = 8'h06;
    localparam logic [7:0] NUM_B = 8'h0a;

    // detector strobes from the core, one cycle each
    typedef struct packed {
        logic sw_rst;
        logic wdt_ovf;
        logic sp_dec;
        logic sp_inc;
        logic [15:0] sp;
        logic undef_op;
        logic mac_trap;
        logic prot_fmt;
        logic odd_word;
        logic odd_branch;
        logic ext_no_bus;
    } htc_det_t;

    // trap entry presented to the core sequencer
    typedef struct packed {
        logic enter;
        logic [23:0] vector;
        logic [7:0] number;
        logic [15:0] push_psw;
        logic [23:0] push_ip;
    } htc_entry_t;

    // whole state of the controller
    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] sts;
        logic [15:0] msk;
        logic [15:0] ovl;
        logic [15:0] unl;
        logic in_a;
        logic in_b;
        logic nmi_s0;
        logic nmi_s1;
        logic nmi_d;
        htc_entry_t ent;
        logic [31:0] prdata;
    } htc_state_t;
endpackage : htc_pkg

// File: htc_trap_ctrl.sv
// Operation
// - all resets vector zero, top priority
// - class A: nmi, overflow, underflow vectors
// - class B shares one vector, number 0Ah
// - each hardware trap sets its flag
// - fixed flag bit positions, others zero
// - flags sticky; still set means re-request
// - software flag set traps like hardware
// - class A preempts running class B
// - nmi before overflow before underflow
// - simultaneous class B enter vector once
// - class B during A only recorded
// - A plus B: B re-pushes popped address
// - stack limits and nmi falling edge
// - odd branch, odd word, missing bus
// - protection fault and undefined opcode
// - software traps, any vector, no flags
// - class A service not interruptible by class A or B
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
module htc_trap_ctrl (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trap detectors and pin
    input wire htc_pkg::htc_det_t det,
    input wire logic nmi_n,
    // core sequencer
    input wire logic core_ready,
    input wire logic [15:0] cur_psw,
    input wire logic [23:0] cur_ip,
    input wire logic return_from_interrupt,
    input wire logic [15:0] pop_psw,
    input wire logic [23:0] pop_ip,
    input wire logic sw_trap,
    input wire logic [6:0] sw_trap_num,
    output htc_pkg::htc_entry_t entry,
    output logic hw_service,
    // interrupt
    output logic irq
);
    import htc_pkg::*;

    htc_state_t s;
    htc_state_t next_s;

    // ****************************************************
    // bus decode
    // ****************************************************
    function automatic logic hit(input logic [15:0] a);
        hit = (a == ADDR_TFR) || (a == ADDR_STS) ||
              (a == ADDR_MSK) || (a == ADDR_OVL) ||
              (a == ADDR_UNL);
    endfunction : hit

    logic wr_acc;
    logic rd_setup;
    logic tfr_wr;
    logic [15:0] hw_set;
    logic rst_ev;
    logic take;
    logic a_go;
    logic b_go;
    logic lv_a;
    logic lv_b;

    // zero wait states; read data is latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit(paddr);
    assign wr_acc = psel && penable && pwrite && hit(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign tfr_wr = wr_acc && (paddr == ADDR_TFR);
    assign prdata = s.prdata;
    assign entry = s.ent;
    assign hw_service = s.in_a || s.in_b;
    assign irq = |(s.sts & s.msk);

    // ****************************************************
    // detection
    // ****************************************************
    always_comb begin
        hw_set = 16'h0000;
        hw_set[B_NMI] = s.nmi_d && !s.nmi_s1;
        hw_set[B_OVF] = det.sp_dec && (det.sp < s.ovl);
        hw_set[B_UNF] = det.sp_inc && (det.sp > s.unl);
        hw_set[B_ODB] = det.odd_branch;
        hw_set[B_ODW] = det.odd_word;
        hw_set[B_BUS] = det.ext_no_bus;
        hw_set[B_PRT] = det.prot_fmt;
        hw_set[B_UND] = det.undef_op;
        hw_set[B_MAC] = det.mac_trap;
    end

    // ****************************************************
    // arbitration and next state
    // ****************************************************
    assign rst_ev = det.sw_rst || det.wdt_ovf;
    // a return opens an entry slot for the pending trap
    assign take = core_ready || return_from_interrupt;
    // levels as they stand after a return this cycle
    assign lv_a = s.in_a && !return_from_interrupt;
    assign lv_b = s.in_b && !(return_from_interrupt && !s.in_a);
    // class A ignores a running class B
    assign a_go = take && !rst_ev && !lv_a && |(s.flags & CLS_A);
    // class B waits for class A to finish
    assign b_go = take && !rst_ev && !a_go && !lv_a && !lv_b &&
                  |(s.flags & CLS_B);

    always_comb begin
        next_s = s;
        next_s.ent.enter = 1'b0;
        // second flop reads only the first
        next_s.nmi_s0 = nmi_n;
        next_s.nmi_s1 = s.nmi_s0;
        next_s.nmi_d = s.nmi_s1;
        if (tfr_wr) begin
            next_s.flags = pwdata[15:0] & (CLS_A | CLS_B);
        end
        // detection wins over a clearing write
        next_s.flags = next_s.flags | hw_set;
        // sticky status, write one to clear, set wins
        if (wr_acc && paddr == ADDR_STS) begin
            next_s.sts = s.sts & ~pwdata[15:0];
        end
        next_s.sts = next_s.sts | hw_set;
        if (wr_acc && paddr == ADDR_MSK) begin
            next_s.msk = pwdata[15:0] & (CLS_A | CLS_B);
        end
        if (wr_acc && paddr == ADDR_OVL) begin
            next_s.ovl = pwdata[15:0];
        end
        if (wr_acc && paddr == ADDR_UNL) begin
            next_s.unl = pwdata[15:0];
        end
        if (rd_setup) begin
            case (paddr)
                ADDR_TFR: next_s.prdata = {16'h0000, s.flags};
                ADDR_STS: next_s.prdata = {16'h0000, s.sts};
                ADDR_MSK: next_s.prdata = {16'h0000, s.msk};
                ADDR_OVL: next_s.prdata = {16'h0000, s.ovl};
                ADDR_UNL: next_s.prdata = {16'h0000, s.unl};
                default: next_s.prdata = 32'h0000_0000;
            endcase
        end
        next_s.in_a = lv_a;
        next_s.in_b = lv_b;
        // stack the status word and return address
        // after a return the popped values re-push
        next_s.ent.push_psw = return_from_interrupt ? pop_psw : cur_psw;
        next_s.ent.push_ip = return_from_interrupt ? pop_ip : cur_ip;
        if (rst_ev) begin
            next_s.ent.enter = 1'b1;
            next_s.ent.vector = VEC_RST;
            next_s.ent.number = NUM_RST;
            next_s.in_a = 1'b0;
            next_s.in_b = 1'b0;
        end else if (a_go) begin
            next_s.ent.enter = 1'b1;
            next_s.in_a = 1'b1;
            if (s.flags[B_NMI]) begin
                next_s.ent.vector = VEC_NMI;
                next_s.ent.number = NUM_NMI;
            end else if (s.flags[B_OVF]) begin
                next_s.ent.vector = VEC_OVF;
                next_s.ent.number = NUM_OVF;
            end else begin
                next_s.ent.vector = VEC_UNF;
                next_s.ent.number = NUM_UNF;
            end
        end else if (b_go) begin
            // one shared vector for class B
            next_s.ent.enter = 1'b1;
            next_s.in_b = 1'b1;
            next_s.ent.vector = VEC_B;
            next_s.ent.number = NUM_B;
        end else if (take && sw_trap) begin
            // software trap: no flag, no level change
            next_s.ent.enter = 1'b1;
            next_s.ent.vector = {15'h0000, sw_trap_num, 2'b00};
            next_s.ent.number = {1'b0, sw_trap_num};
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.flags <= RST_FLAGS;
            s.ovl <= RST_OVL;
            s.unl <= RST_UNL;
            // pin idles high, avoids a false edge
            s.nmi_s0 <= 1'b1;
            s.nmi_s1 <= 1'b1;
            s.nmi_d <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_reset_vector: assert property (
        rst_ev |=> s.ent.enter && s.ent.vector == VEC_RST &&
                   !s.in_a && !s.in_b)
        else $error("reset did not vector to zero");
    a_nmi_first: assert property (
        a_go && s.flags[B_NMI] |=>
            s.ent.vector == VEC_NMI && s.ent.number == NUM_NMI)
        else $error("nmi not served first");
    a_b_vector: assert property (
        b_go |=> s.ent.enter && s.ent.vector == VEC_B && s.in_b)
        else $error("class b vector wrong");
    a_b_once: assert property (
        s.ent.enter && s.ent.number == NUM_B |->
            !$past(s.in_b) || $past(return_from_interrupt))
        else $error("class b entered twice");
    a_b_waits_a: assert property (
        s.ent.enter && s.ent.number == NUM_B |-> !s.in_a)
        else $error("class b entered during class a");
    a_a_preempt: assert property (
        s.in_b && !return_from_interrupt && take && !rst_ev &&
        |(s.flags & CLS_A) && !s.in_a |=> s.in_a && s.ent.enter)
        else $error("class a did not preempt class b");
    a_nmi_edge: assert property (
        s.nmi_d && !s.nmi_s1 |=> s.flags[B_NMI] && s.sts[B_NMI])
        else $error("nmi edge not flagged");
    a_ovf_limit: assert property (
        det.sp_dec && det.sp < s.ovl |=> s.flags[B_OVF])
        else $error("stack overflow not flagged");
    a_odd_branch: assert property (
        det.odd_branch |=> s.flags[B_ODB])
        else $error("odd branch not flagged");
    a_flag_sticky: assert property (
        s.flags[B_UND] && !tfr_wr |=> s.flags[B_UND])
        else $error("flag lost without a write");
    a_sw_vector: assert property (
        take && sw_trap && !rst_ev && !a_go && !b_go |=>
            s.ent.vector == {15'h0000, $past(sw_trap_num), 2'b00} &&
            $stable(s.in_a) && $stable(s.in_b))
        else $error("software trap vector wrong");
    a_repush: assert property (
        return_from_interrupt && s.in_a && b_go |=> s.ent.push_ip == $past(pop_ip))
        else $error("popped address not re-pushed");

    c_nested: cover property (s.in_b ##1 s.in_a);
    c_ab_same: cover property (a_go && |(s.flags & CLS_B));
    c_repush: cover property (return_from_interrupt && s.in_a && b_go);
    c_sw_trap: cover property (take && sw_trap && !a_go && !b_go);
endmodule : htc_trap_ctrl

// File: htc_core_model.sv
`timescale 1ns/1ns
// ****************************************
// core sequencer model
// ****************************************
module htc_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic slow,
    input wire logic do_return_from_interrupt,
    // controller side
    input wire htc_pkg::htc_entry_t entry,
    output logic core_ready,
    output logic [15:0] cur_psw,
    output logic [23:0] cur_ip,
    output logic return_from_interrupt,
    output logic [15:0] pop_psw,
    output logic [23:0] pop_ip
);
    import htc_pkg::*;
    logic [39:0] stk[$];
    // stack and restore
    // pop lines flip when idle so stale values never look valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ready <= 1'b0;
            cur_psw <= 16'h0000;
            cur_ip <= 24'h00_0100;
            return_from_interrupt <= 1'b0;
            pop_psw <= 16'h0000;
            pop_ip <= 24'h00_0000;
            stk.delete();
        end else begin
            core_ready <= !slow || !core_ready;
            cur_psw <= cur_psw + 16'h0011;
            cur_ip <= cur_ip + 24'h00_0002;
            return_from_interrupt <= do_return_from_interrupt && stk.size() > 0;
            if (do_return_from_interrupt && stk.size() > 0) begin
                {pop_psw, pop_ip} <= stk.pop_back();
            end else begin
                pop_psw <= ~pop_psw;
                pop_ip <= ~pop_ip;
            end
            if (entry.enter && entry.number != NUM_RST) begin
                stk.push_back({entry.push_psw, entry.push_ip});
            end else if (entry.enter) begin
                stk.delete();
            end
        end
    end
endmodule : htc_core_model

// File: hardware_trap_controller_bench.sv
`timescale 1ns/1ns
module hardware_trap_controller_bench;
    import htc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic nmi_n, core_ready, return_from_interrupt, sw_trap, hw_service, irq, slow, do_return_from_interrupt;
    logic [15:0] paddr, cur_psw, pop_psw;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] cur_ip, pop_ip, ip_a;
    logic [15:0] psw_a;
    logic [6:0] sw_trap_num;
    htc_det_t det;
    htc_entry_t entry;
    int err_count, checks, exp_flags, i, n;
    int bmap[6] = '{B_BUS, B_ODB, B_ODW, B_PRT, B_MAC, B_UND};
    htc_trap_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .det, .nmi_n, .core_ready,
        .cur_psw, .cur_ip, .return_from_interrupt, .pop_psw, .pop_ip, .sw_trap, .sw_trap_num,
        .entry, .hw_service, .irq);
    htc_core_model core_u (.pclk, .presetn, .slow, .do_return_from_interrupt, .entry,
        .core_ready, .cur_psw, .cur_ip, .return_from_interrupt, .pop_psw, .pop_ip);
    // ****************************************
    // clock, checks and bus tasks
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // request held until pready is seen at an edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    task strobe(input logic [25:0] d);
        @(posedge pclk);
        det <= d;
        @(posedge pclk);
        det <= '0;
    endtask : strobe
    // bounded wait for an entry, then vector and number
    task wait_entry(input logic [23:0] v, input logic [7:0] nm);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            #1 k++;
        end while (entry.enter !== 1'b1 && k < 40);
        chk({entry.vector, entry.number}, {v, nm});
    endtask : wait_entry
    task no_entry(input int c);
        repeat (c) begin
            @(posedge pclk);
            #1 chk(32'(entry.enter), 32'h0000_0000);
        end
    endtask : no_entry
    task ret;
        @(posedge pclk);
        do_return_from_interrupt <= 1'b1;
        @(posedge pclk);
        do_return_from_interrupt <= 1'b0;
    endtask : ret
    task clr_ret;
        apb(1'b1, ADDR_TFR, 32'h0000_0000);
        ret();
    endtask : clr_ret
    // hang guard well beyond the expected run
    initial begin
        #(6000 * 100);
        err_count++;
        report_and_stop();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h838b_ef5d));
        {presetn, psel, penable, pwrite, sw_trap, slow, do_return_from_interrupt} = '0;
        {paddr, pwdata, sw_trap_num, det} = '0;
        {nmi_n, err_count, checks} = '0;
        nmi_n = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_TFR, 32'(RST_FLAGS));
        apb(1'b1, ADDR_TFR, 32'h0000_1f30);
        rdc(ADDR_TFR, 32'h0000_0000);
        apb(1'b0, 16'hffa0, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        // each class-b source alone, then all at once
        for (i = 0; i < 6; i++) begin
            exp_flags = 1 << bmap[i];
            strobe(26'd1 << i);
            wait_entry(VEC_B, NUM_B);
            chk(32'(hw_service), 32'h0000_0001);
            rdc(ADDR_TFR, 32'(exp_flags));
            clr_ret();
        end
        strobe(26'h000_003f);
        wait_entry(VEC_B, NUM_B);
        no_entry(6);
        rdc(ADDR_TFR, 32'(CLS_B));
        clr_ret();
        chk(32'(irq), 32'h0000_0000);
        // irq follows the registers only after the write edge settles
        apb(1'b1, ADDR_MSK, 32'(CLS_B));
        #1 chk(32'(irq), 32'h0000_0001);
        apb(1'b1, ADDR_STS, 32'(CLS_B));
        #1 chk(32'(irq), 32'h0000_0000);
        // software set on a slow core, flag kept set
        slow <= 1'b1;
        apb(1'b1, ADDR_TFR, 32'h0000_0080);
        wait_entry(VEC_B, NUM_B);
        ret();
        wait_entry(VEC_B, NUM_B);
        clr_ret();
        no_entry(6);
        slow <= 1'b0;
        // class-a order
        apb(1'b1, ADDR_TFR, 32'(CLS_A));
        wait_entry(VEC_NMI, NUM_NMI);
        apb(1'b1, ADDR_TFR, 32'h0000_6000);
        ret();
        wait_entry(VEC_OVF, NUM_OVF);
        apb(1'b1, ADDR_TFR, 32'h0000_2000);
        ret();
        wait_entry(VEC_UNF, NUM_UNF);
        clr_ret();
        // stack limits, the limit value itself does not trap
        apb(1'b1, ADDR_OVL, 32'h0000_1000);
        strobe((26'd1 << 23) | (26'h0_1000 << 6));
        no_entry(4);
        strobe((26'd1 << 23) | (26'h0_0fff << 6));
        wait_entry(VEC_OVF, NUM_OVF);
        clr_ret();
        apb(1'b1, ADDR_UNL, 32'h0000_2000);
        strobe((26'd1 << 22) | (26'h0_2001 << 6));
        wait_entry(VEC_UNF, NUM_UNF);
        clr_ret();
        // nmi pin during class-b, class-b during class-a
        strobe(26'd1 << 2);
        wait_entry(VEC_B, NUM_B);
        @(posedge pclk);
        nmi_n <= 1'b0;
        wait_entry(VEC_NMI, NUM_NMI);
        strobe(26'd1 << 1);
        no_entry(6);
        rdc(ADDR_TFR, 32'h0000_8006);
        apb(1'b1, ADDR_TFR, 32'h0000_0002);
        nmi_n <= 1'b1;
        ret();
        no_entry(6);
        ret();
        wait_entry(VEC_B, NUM_B);
        clr_ret();
        // nmi and undefined opcode flags land in one cycle
        @(posedge pclk);
        nmi_n <= 1'b0;
        repeat (2) @(posedge pclk);
        det <= 26'd1 << 5;
        @(posedge pclk);
        det <= '0;
        wait_entry(VEC_NMI, NUM_NMI);
        ip_a = entry.push_ip;
        psw_a = entry.push_psw;
        rdc(ADDR_TFR, 32'h0000_8080);
        apb(1'b1, ADDR_TFR, 32'h0000_0080);
        nmi_n <= 1'b1;
        ret();
        wait_entry(VEC_B, NUM_B);
        chk(32'(entry.push_ip), 32'(ip_a));
        chk(32'(entry.push_psw), 32'(psw_a));
        clr_ret();
        // reset strobes drop any service level
        for (i = 24; i < 26; i++) begin
            strobe(26'd1 << 2);
            wait_entry(VEC_B, NUM_B);
            apb(1'b1, ADDR_TFR, 32'h0000_0000);
            strobe(26'd1 << i);
            wait_entry(VEC_RST, NUM_RST);
            no_entry(2);
            chk(32'(hw_service), 32'h0000_0000);
        end
        // software traps leave the flags alone
        repeat (3) begin
            n = 1 + $urandom % 127;
            @(posedge pclk);
            sw_trap_num <= 7'(n);
            sw_trap <= 1'b1;
            @(posedge pclk);
            sw_trap <= 1'b0;
            wait_entry(24'(n * 4), 8'(n));
            rdc(ADDR_TFR, 32'h0000_0000);
            ret();
        end
        report_and_stop();
    end
endmodule : hardware_trap_controller_bench
